// ### rtl/srp_pkg.sv
package srp_pkg;

  localparam int ADDR_W    = 20;
  localparam int DATA_W    = 32;
  localparam int LANES     = DATA_W / 8;
  localparam int KEY_W     = 4;
  localparam int NUM_KEYS  = 16;
  localparam int BLK_SHIFT = 11;                     // 2048-byte protection blocks
  localparam int BLK_W     = ADDR_W - BLK_SHIFT;
  localparam int NUM_BLKS  = 1 << BLK_W;

  localparam logic [ADDR_W-1:0] RESERVED_BYTES = 20'h00280;  // 640 bytes
  localparam logic [ADDR_W-1:0] RELOC_TABLE    = 20'h00200;
  localparam int                RELOC_ENTRY_SH = 2;          // One word per base

  // Cabinet switches give address bits 19:13; a cabinet spans 131072 bytes
  localparam int CAB_SW_W  = 7;
  localparam int CAB_SHIFT = ADDR_W - CAB_SW_W;
  localparam int CAB_SPAN  = 16;

  // Installed size counted in 65,536-byte units
  localparam int UNIT_SHIFT = 16;
  localparam int UNITS_W    = 5;
  localparam int MIN_UNITS  = 2;
  localparam int FINE_UNITS = 4;
  localparam int MAX_UNITS  = 16;

  localparam logic PROT_WRITE = 1'b0;
  localparam logic PROT_RW    = 1'b1;

  localparam logic [KEY_W-1:0]  KEY_RST  = 4'h0;
  localparam logic [ADDR_W-1:0] BASE_RST = 20'h00000;

  typedef logic [ADDR_W-1:0] srp_addr_t;
  typedef enum logic [1:0] {SRP_BYTE, SRP_HALF, SRP_WORD, SRP_DWORD} srp_size_e;

  // Odd parity: a good group has an odd count of ones including its parity bit
  function automatic logic srp_addr_par_ok(input srp_addr_t a, input logic p);
    return ^{a, p};
  endfunction

  function automatic logic srp_data_par_ok(input logic [DATA_W-1:0] d,
                                           input logic [LANES-1:0]  p);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < LANES; i++) begin
      ok = ok & (^{d[8*i +: 8], p[i]});
    end
    return ok;
  endfunction

  function automatic logic [LANES-1:0] srp_data_par(input logic [DATA_W-1:0] d);
    logic [LANES-1:0] p;
    p = '0;
    for (int i = 0; i < LANES; i++) begin
      p[i] = ~^d[8*i +: 8];
    end
    return p;
  endfunction

endpackage

// ### rtl/srp_key_if.sv
`timescale 1ns/1ps
interface srp_key_if;
  import srp_pkg::*;
  logic [BLK_W-1:0] lk_blk;
  logic [KEY_W-1:0] lk_key;
  logic             lk_mode;
  logic             wr_en;
  logic [BLK_W-1:0] wr_blk;
  logic [KEY_W-1:0] wr_key;
  logic             wr_mode;
  modport store (input lk_blk, wr_en, wr_blk, wr_key, wr_mode, output lk_key, lk_mode);
  modport user  (output lk_blk, wr_en, wr_blk, wr_key, wr_mode, input lk_key, lk_mode);
endinterface

// ### rtl/srp_key_store.sv
`timescale 1ns/1ps
module srp_key_store
  import srp_pkg::*;
(
  input  wire logic clk,
  input  wire logic srst,
  srp_key_if.store  kif
);

  logic [KEY_W-1:0] key_q  [NUM_BLKS];
  logic             mode_q [NUM_BLKS];

  // One key and one protection mode per block, set by the supervisor
  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < NUM_BLKS; i++) begin
        key_q[i]  <= KEY_RST;
        mode_q[i] <= PROT_WRITE;
      end
    end else if (kif.wr_en) begin
      key_q[kif.wr_blk]  <= kif.wr_key;
      mode_q[kif.wr_blk] <= kif.wr_mode;
    end
  end

  // Lookup is combinational so the check finishes in one cycle
  assign kif.lk_key  = key_q[kif.lk_blk];
  assign kif.lk_mode = mode_q[kif.lk_blk];

endmodule

// ### rtl/srp_storage_guard.sv
`timescale 1ns/1ps
// Functional notes
// - User-program addresses get the active relocation base added to them.
// - A change of the status-word key reloads the base from storage by hardware.
// - Sixteen bases sit in low storage and the one for the current key is held locally.
// - Every 2048-byte block carries one of sixteen keys and every access is checked.
// - A matching requester key lets the read or write go ahead.
// - A mismatch on a write-protected block lets reads through and stops writes.
// - A mismatch on a read/write-protected block stops reads and writes.
// - Every access refused by the key check raises a program exception, unless a parity or address error is flagged instead.
// - Storage is byte addressed from zero up to 1,048,575, groups by leftmost byte.
// - Address and data of every transfer are checked for odd parity.
// - Each cabinet takes its start address high bits from seven switches.
// - The low 640 bytes are kept for operating information.
// - Installed size is 128K up, in 64K steps to 256K and 128K steps beyond.
module srp_storage_guard
  import srp_pkg::*;
#(
  parameter int N_CAB = 8
) (
  input  wire logic                        clk,
  input  wire logic                        srst,
  input  wire logic [srp_pkg::KEY_W-1:0]   program_status_word_key,
  input  wire logic                        req_valid,
  output logic                             req_ready,
  input  wire logic                        req_write,
  input  wire logic                        req_reloc,
  input  srp_pkg::srp_size_e               req_size,
  input  wire logic [srp_pkg::KEY_W-1:0]   req_key,
  input  wire logic [srp_pkg::ADDR_W-1:0]  req_addr,
  input  wire logic                        req_addr_par,
  input  wire logic [srp_pkg::DATA_W-1:0]  req_wdata,
  input  wire logic [srp_pkg::LANES-1:0]   req_wpar,
  output logic                             rsp_valid,
  output logic [srp_pkg::DATA_W-1:0]       rsp_rdata,
  output logic [srp_pkg::LANES-1:0]        rsp_rpar,
  output logic                             rsp_prot_exc,
  output logic                             rsp_par_err,
  output logic                             rsp_addr_err,
  output logic [srp_pkg::ADDR_W-1:0]       active_base,
  output logic                             base_valid,
  output logic                             base_par_err,
  input  wire logic                        keyset_valid,
  input  wire logic [srp_pkg::BLK_W-1:0]   keyset_blk,
  input  wire logic [srp_pkg::KEY_W-1:0]   keyset_key,
  input  wire logic                        keyset_mode,
  input  wire logic [srp_pkg::UNITS_W-1:0] cfg_units,
  input  wire logic [N_CAB*srp_pkg::CAB_SW_W-1:0] cab_sw,
  output logic                             mem_req,
  output logic                             mem_write,
  output logic [srp_pkg::ADDR_W-1:0]       mem_addr,
  output logic                             mem_addr_par,
  output srp_pkg::srp_size_e               mem_size,
  output logic [srp_pkg::DATA_W-1:0]       mem_wdata,
  output logic [srp_pkg::LANES-1:0]        mem_wpar,
  output logic [N_CAB-1:0]                 mem_cab_sel,
  input  wire logic                        mem_ack,
  input  wire logic [srp_pkg::DATA_W-1:0]  mem_rdata,
  input  wire logic [srp_pkg::LANES-1:0]   mem_rpar
);
  import srp_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_BASE_WT, ST_CHECK, ST_MEM_WT} srp_state_e;

  srp_state_e        state_q;
  srp_addr_t         base_q;
  logic              base_valid_q;
  logic [KEY_W-1:0]  loaded_key_q;
  srp_addr_t         phys_q;
  logic              write_q;
  logic              reloc_q;
  srp_size_e         size_q;
  logic [KEY_W-1:0]  key_q;
  logic [DATA_W-1:0] wdata_q;
  logic              apar_ok_q;
  logic              wpar_ok_q;
  logic              align_ok_q;
  logic              ready_q;
  logic              rsp_valid_q;
  logic [DATA_W-1:0] rsp_rdata_q;
  logic [LANES-1:0]  rsp_rpar_q;
  logic              prot_q;
  logic              perr_q;
  logic              aerr_q;
  logic              bperr_q;
  logic              mreq_q;
  logic              mwrite_q;
  srp_addr_t         maddr_q;
  srp_size_e         msize_q;
  logic [DATA_W-1:0] mwdata_q;
  logic [N_CAB-1:0]  mcab_q;

  srp_key_if kif ();

  srp_key_store u_keys (
    .clk  (clk),
    .srst (srst),
    .kif  (kif)
  );

  // Supervisor key loads; lookup always follows the relocated address
  assign kif.wr_en   = keyset_valid;
  assign kif.wr_blk  = keyset_blk;
  assign kif.wr_key  = keyset_key;
  assign kif.wr_mode = keyset_mode;
  assign kif.lk_blk  = phys_q[ADDR_W-1:BLK_SHIFT];

  logic              need_reload;
  logic              take_req;
  srp_addr_t         tbl_addr;
  srp_addr_t         tgt_addr;
  logic [N_CAB-1:0]  cab_sel;
  logic              size_ok;
  logic              in_range;
  logic              key_match;
  logic              prot_fail;
  logic              align_ok;
  logic [CAB_SW_W-1:0] sw;
  logic [CAB_SW_W-1:0] hi;

  // Reload whenever the status-word key differs from the one whose table slot was last read
  assign need_reload = !base_valid_q || (program_status_word_key != loaded_key_q);
  assign take_req    = req_valid && ready_q && !need_reload;
  assign tbl_addr    = RELOC_TABLE
                     | srp_addr_t'({program_status_word_key, {RELOC_ENTRY_SH{1'b0}}});
  assign tgt_addr    = (state_q == ST_IDLE) ? tbl_addr : phys_q;

  // Operands addressed by the leftmost byte must sit on their own length
  always_comb begin
    case (req_size)
      SRP_HALF:  align_ok = (req_addr[0] == 1'b0);
      SRP_WORD:  align_ok = (req_addr[1:0] == 2'b00);
      SRP_DWORD: align_ok = (req_addr[2:0] == 3'b000);
      default:   align_ok = 1'b1;
    endcase
  end

  // Cabinet decode: the first cabinet whose switch window covers the address wins
  always_comb begin
    cab_sel = '0;
    hi      = tgt_addr[ADDR_W-1:CAB_SHIFT];
    sw      = '0;
    for (int c = N_CAB - 1; c >= 0; c--) begin
      sw = cab_sw[c*CAB_SW_W +: CAB_SW_W];
      if (hi >= sw && ({1'b0, hi} < ({1'b0, sw} + (CAB_SW_W+1)'(CAB_SPAN)))) begin
        cab_sel = '0;
        cab_sel[c] = 1'b1;
      end
    end
  end

  // Only the documented capacity steps are accepted; otherwise nothing is mapped
  assign size_ok  = (cfg_units >= UNITS_W'(MIN_UNITS)) && (cfg_units <= UNITS_W'(MAX_UNITS))
                 && ((cfg_units <= UNITS_W'(FINE_UNITS)) || !cfg_units[0]);
  assign in_range = size_ok && (cab_sel != '0)
                 && ({1'b0, phys_q} < ((ADDR_W+1)'(cfg_units) << UNIT_SHIFT));

  // Key check against the block's key and protection mode
  assign key_match = (key_q == kif.lk_key);
  always_comb begin
    if (key_match) begin
      prot_fail = 1'b0;
    end else if (kif.lk_mode == PROT_RW) begin
      prot_fail = 1'b1;
    end else begin
      prot_fail = write_q;
    end
    // User programs never reach the reserved low area, whatever the key
    if (reloc_q && phys_q < RESERVED_BYTES) begin
      prot_fail = 1'b1;
    end
  end

  // Sequencer: base reload has priority over new requests
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (need_reload) begin
            state_q <= ST_BASE_WT;
          end else if (take_req) begin
            state_q <= ST_CHECK;
          end
        end
        ST_BASE_WT: if (mem_ack) state_q <= ST_IDLE;
        ST_CHECK: begin
          if (apar_ok_q && wpar_ok_q && align_ok_q && in_range && !prot_fail) begin
            state_q <= ST_MEM_WT;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_MEM_WT: if (mem_ack) state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Ready only in idle, so a request is never held half-taken
  always_ff @(posedge clk) begin
    if (srst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= (state_q == ST_IDLE) ? !(need_reload || take_req)
               : ((state_q == ST_CHECK && !(apar_ok_q && wpar_ok_q && align_ok_q
                   && in_range && !prot_fail)) || mem_ack && state_q != ST_CHECK);
    end
  end

  // Request capture; relocation is applied only to user-program references
  always_ff @(posedge clk) begin
    if (srst) begin
      phys_q     <= '0;
      write_q    <= 1'b0;
      reloc_q    <= 1'b0;
      size_q     <= SRP_BYTE;
      key_q      <= KEY_RST;
      wdata_q    <= '0;
      apar_ok_q  <= 1'b0;
      wpar_ok_q  <= 1'b0;
      align_ok_q <= 1'b0;
    end else if (state_q == ST_IDLE && take_req) begin
      phys_q     <= req_addr + (req_reloc ? base_q : '0);  // Wraps within 1 MB
      write_q    <= req_write;
      reloc_q    <= req_reloc;
      size_q     <= req_size;
      key_q      <= req_key;
      wdata_q    <= req_wdata;
      apar_ok_q  <= srp_addr_par_ok(req_addr, req_addr_par);
      wpar_ok_q  <= !req_write || srp_data_par_ok(req_wdata, req_wpar);
      align_ok_q <= align_ok;
    end
  end

  // Local copy of the current base; a bad-parity entry keeps the old one
  always_ff @(posedge clk) begin
    if (srst) begin
      base_q       <= BASE_RST;
      base_valid_q <= 1'b0;
      loaded_key_q <= KEY_RST;
      bperr_q      <= 1'b0;
    end else begin
      bperr_q <= 1'b0;
      if (state_q == ST_IDLE && need_reload) begin
        loaded_key_q <= program_status_word_key;
      end
      if (state_q == ST_BASE_WT && mem_ack) begin
        base_valid_q <= 1'b1;
        if (srp_data_par_ok(mem_rdata, mem_rpar)) begin
          base_q <= mem_rdata[ADDR_W-1:0];
        end else begin
          bperr_q <= 1'b1;
        end
      end
    end
  end

  // Storage request: one-cycle strobe, address and data held until the ack
  always_ff @(posedge clk) begin
    if (srst) begin
      mreq_q   <= 1'b0;
      mwrite_q <= 1'b0;
      maddr_q  <= '0;
      msize_q  <= SRP_BYTE;
      mwdata_q <= '0;
      mcab_q   <= '0;
    end else begin
      mreq_q <= 1'b0;
      if (state_q == ST_IDLE && need_reload) begin
        mreq_q   <= 1'b1;
        mwrite_q <= 1'b0;
        maddr_q  <= tbl_addr;
        msize_q  <= SRP_WORD;
        mcab_q   <= cab_sel;
      end else if (state_q == ST_CHECK && apar_ok_q && wpar_ok_q && align_ok_q
                   && in_range && !prot_fail) begin
        mreq_q   <= 1'b1;
        mwrite_q <= write_q;
        maddr_q  <= phys_q;
        msize_q  <= size_q;
        mwdata_q <= wdata_q;
        mcab_q   <= cab_sel;
      end
    end
  end

  // Answers: parity first, then address, then protection
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= '0;
      rsp_rpar_q  <= '0;
      prot_q      <= 1'b0;
      perr_q      <= 1'b0;
      aerr_q      <= 1'b0;
    end else begin
      rsp_valid_q <= 1'b0;
      prot_q      <= 1'b0;
      perr_q      <= 1'b0;
      aerr_q      <= 1'b0;
      if (state_q == ST_CHECK) begin
        if (!(apar_ok_q && wpar_ok_q)) begin
          rsp_valid_q <= 1'b1;
          perr_q      <= 1'b1;
        end else if (!(align_ok_q && in_range)) begin
          rsp_valid_q <= 1'b1;
          aerr_q      <= 1'b1;
        end else if (prot_fail) begin
          rsp_valid_q <= 1'b1;
          prot_q      <= 1'b1;
        end
      end else if (state_q == ST_MEM_WT && mem_ack) begin
        rsp_valid_q <= 1'b1;
        rsp_rdata_q <= write_q ? '0 : mem_rdata;
        rsp_rpar_q  <= write_q ? srp_data_par('0) : mem_rpar;
        perr_q      <= !write_q && !srp_data_par_ok(mem_rdata, mem_rpar);
      end
    end
  end

  assign req_ready    = ready_q;
  assign rsp_valid    = rsp_valid_q;
  assign rsp_rdata    = rsp_rdata_q;
  assign rsp_rpar     = rsp_rpar_q;
  assign rsp_prot_exc = prot_q;
  assign rsp_par_err  = perr_q;
  assign rsp_addr_err = aerr_q;
  assign active_base  = base_q;
  assign base_valid   = base_valid_q;
  assign base_par_err = bperr_q;
  assign mem_req      = mreq_q;
  assign mem_write    = mwrite_q;
  assign mem_addr     = maddr_q;
  // Parity is regenerated on the physical address, since relocation changed it
  assign mem_addr_par = ~^maddr_q;
  assign mem_size     = msize_q;
  assign mem_wdata    = mwdata_q;
  assign mem_wpar     = srp_data_par(mwdata_q);
  assign mem_cab_sel  = mcab_q;

endmodule

// ### verif/srp_guard_monitor.sv
`timescale 1ns/1ps
module srp_guard_monitor #(
  parameter int N_CAB = 8
) (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic [srp_pkg::KEY_W-1:0]  program_status_word_key,
  input  wire logic                       req_valid,
  input  wire logic                       req_ready,
  input  wire logic                       req_write,
  input  wire logic                       req_reloc,
  input  srp_pkg::srp_size_e              req_size,
  input  wire logic [srp_pkg::ADDR_W-1:0] req_addr,
  input  wire logic                       req_addr_par,
  input  wire logic [srp_pkg::DATA_W-1:0] req_wdata,
  input  wire logic                       rsp_valid,
  input  wire logic                       rsp_prot_exc,
  input  wire logic                       rsp_par_err,
  input  wire logic                       rsp_addr_err,
  input  wire logic [srp_pkg::ADDR_W-1:0] active_base,
  input  wire logic                       base_valid,
  input  wire logic                       base_par_err,
  input  wire logic                       mem_req,
  input  wire logic                       mem_write,
  input  wire logic [srp_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic                       mem_addr_par,
  input  wire logic [srp_pkg::DATA_W-1:0] mem_wdata,
  input  wire logic [N_CAB-1:0]           mem_cab_sel,
  input  wire logic                       mem_ack,
  input  wire logic [srp_pkg::DATA_W-1:0] mem_rdata,
  input  wire logic [srp_pkg::LANES-1:0]  mem_rpar
);
  import srp_pkg::*;
  logic take;
  logic rd_ok;
  // Handshake edge, shared by several properties, and read-data parity
  assign take  = req_valid & req_ready;
  assign rd_ok = (^{mem_rdata[7:0], mem_rpar[0]}) & (^{mem_rdata[15:8], mem_rpar[1]})
               & (^{mem_rdata[23:16], mem_rpar[2]}) & (^{mem_rdata[31:24], mem_rpar[3]});
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_err_flags_one: assert property (rsp_valid |-> $onehot0({rsp_prot_exc, rsp_par_err,
    rsp_addr_err})) else $error("more than one error flag");
  chk_refused_quiet: assert property ((rsp_prot_exc || rsp_addr_err) |-> !$past(mem_req)
    && !$past(mem_req, 2)) else $error("refused access reached storage");
  chk_reloc_add_base: assert property (take ##2 mem_req |-> mem_addr == srp_addr_t'($past(
    req_addr, 2) + ($past(req_reloc, 2) ? $past(active_base, 2) : '0)))
    else $error("physical address wrong");
  chk_low_area_refused: assert property (take && req_reloc && srp_addr_t'(req_addr + active_base)
    < RESERVED_BYTES |-> ##2 rsp_valid && (rsp_prot_exc || rsp_par_err || rsp_addr_err))
    else $error("user reference to low area not refused");
  chk_write_passes: assert property (take ##2 mem_req |-> mem_write == $past(req_write, 2)
    && (!mem_write || mem_wdata == $past(req_wdata, 2)))
    else $error("storage transfer differs from request");
  chk_out_addr_par: assert property (mem_req |-> ^{mem_addr, mem_addr_par})
    else $error("storage address parity not odd");
  chk_in_addr_par: assert property (take && !(^{req_addr, req_addr_par}) |-> ##2 rsp_valid
    && rsp_par_err) else $error("bad address parity not flagged");
  chk_misalign_err: assert property (take && !req_write && (^{req_addr, req_addr_par})
    && (req_addr & ((20'h1 << req_size) - 20'h1)) != 20'h0 |-> ##2 rsp_valid && rsp_addr_err)
    else $error("misaligned access not flagged");
  chk_read_par_flag: assert property (mem_ack && !mem_write && !rd_ok |=> (rsp_valid
    && rsp_par_err) || base_par_err) else $error("read parity error lost");
  chk_cab_one_hot: assert property (mem_req |-> $onehot(mem_cab_sel))
    else $error("cabinet select not one-hot");
  chk_key_reload: assert property (base_valid && req_ready && !req_valid
    && $changed(program_status_word_key) |-> ##[1:4] mem_req && mem_addr == RELOC_TABLE
    + (srp_addr_t'(program_status_word_key) << RELOC_ENTRY_SH))
    else $error("base not fetched on key change");
endmodule

bind srp_storage_guard srp_guard_monitor #(.N_CAB(N_CAB)) mon_u (.*);

// ### verif/srp_mem_model.sv
`timescale 1ns/1ps
module srp_mem_model (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       mem_req,
  input  wire logic                       mem_write,
  input  wire logic [srp_pkg::ADDR_W-1:0] mem_addr,
  input  wire logic [srp_pkg::DATA_W-1:0] mem_wdata,
  input  wire logic [3:0]                 lat,
  input  wire logic                       bad_rpar,
  output logic                            mem_ack,
  output logic [srp_pkg::DATA_W-1:0]      mem_rdata,
  output logic [srp_pkg::LANES-1:0]       mem_rpar
);
  import srp_pkg::*;
  logic [DATA_W-1:0] mem [logic [17:0]];
  logic [17:0]       wa;
  logic [DATA_W-1:0] dq;
  int                cnt;
  // Word cells; unwritten cells read back their word index. Latency set by lat
  always @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rdata <= ~mem_rdata; // Released bus toggles each cycle so stale data looks good only on alternate cycles
    mem_rpar <= ~mem_rpar;
    if (srst) begin
      cnt = 0;
      mem_rdata <= '0;
      mem_rpar <= '0;
    end else if (mem_req) begin
      wa = mem_addr[19:2];
      if (mem_write) mem[wa] = mem_wdata;
      cnt = lat;
    end else if (cnt > 0) cnt--;
    if (cnt == 1) begin
      dq = mem.exists(wa) ? mem[wa] : {14'h0000, wa};
      mem_ack <= 1'b1;
      mem_rdata <= dq;
      for (int i = 0; i < 4; i++) mem_rpar[i] <= ~^dq[8*i +: 8] ^ (bad_rpar && i == 0);
    end
  end
endmodule

// ### verif/tb.sv
`timescale 1ns/1ps
module tb;
  import srp_pkg::*;
  logic              clk, srst, req_valid, req_ready, req_write, req_reloc, req_addr_par;
  logic              rsp_valid, rsp_prot_exc, rsp_par_err, rsp_addr_err, base_valid;
  logic              base_par_err, keyset_valid, keyset_mode, mem_req, mem_write;
  logic              mem_addr_par, mem_ack, bad_rpar, seen_mem;
  logic [3:0]        program_status_word_key, req_key, keyset_key, lat, req_wpar;
  logic [3:0]        rsp_rpar, mem_wpar, mem_rpar, r_par;
  srp_size_e         req_size, mem_size;
  logic [ADDR_W-1:0] req_addr, active_base, mem_addr, m_addr;
  logic [DATA_W-1:0] req_wdata, rsp_rdata, mem_wdata, mem_rdata, r_data;
  logic [8:0]        keyset_blk;
  logic [4:0]        cfg_units;
  logic [55:0]       cab_sw;
  logic [7:0]        mem_cab_sel, m_sel;
  logic [2:0]        r_flg;
  int                n_mismatch, num_checks;

  srp_storage_guard dut_u (.*);
  srp_mem_model mem_u (.*);

  always #4 clk = ~clk;
  // Remember the last storage strobe seen during an access
  always @(posedge clk) if (mem_req) begin
    seen_mem <= 1'b1;
    m_addr <= mem_addr;
    m_sel <= mem_cab_sel;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    if (n == 300) n_mismatch++;
  endtask
  function automatic logic [3:0] opar(input logic [31:0] d);
    for (int i = 0; i < 4; i++) opar[i] = ~^d[8*i +: 8];
  endfunction
  // One request held until taken; bad flips address or data parity
  task automatic acc(input logic w, input logic rl, input srp_size_e sz, input logic [3:0] k,
                     input logic [19:0] a, input logic [31:0] d, input logic [1:0] bad);
    int n;
    req_write = w;
    req_reloc = rl;
    req_size = sz;
    req_key = k;
    req_addr = a;
    req_wdata = d;
    req_addr_par = ~^a ^ bad[0];
    req_wpar = opar(d) ^ {3'b000, bad[1]};
    seen_mem = 1'b0;
    req_valid = 1'b1;
    wait_ready;
    tick;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    if (n == 300) n_mismatch++;
    r_data = rsp_rdata;
    r_par = rsp_rpar;
    r_flg = {rsp_par_err, rsp_addr_err, rsp_prot_exc};
  endtask
  task automatic kset(input logic [8:0] b, input logic [3:0] k, input logic m);
    keyset_blk = b;
    keyset_key = k;
    keyset_mode = m;
    keyset_valid = 1'b1;
    tick;
    keyset_valid = 1'b0;
    tick;
  endtask
  // Key change: the base is fetched from its table slot before requests resume
  task automatic setkey(input logic [3:0] k, input logic [19:0] base);
    int n;
    wait_ready;
    // Same key: the reload after reset already fetched this slot
    if (k != program_status_word_key) seen_mem = 1'b0;
    program_status_word_key = k;
    n = 0;
    while (seen_mem !== 1'b1 && n < 300) begin
      tick;
      n++;
    end
    wait_ready;
    chk(seen_mem, 1);
    chk(m_addr, 20'h00200 + 4 * k);
    chk(active_base, base);
    chk(base_valid, 1);
  endtask
  task automatic t_reserved;
    acc(1, 1, SRP_WORD, 0, 20'h00100, 32'h1234_5678, 0);
    chk(r_flg, 3'b001);
    chk(seen_mem, 0);
    acc(0, 0, SRP_WORD, 0, 20'h00100, 0, 0);
    chk(r_flg, 0);
    chk(r_data, 32'h40);
  endtask
  task automatic t_reloc;
    kset(9'h000, 4'h0, 1'b1);
    kset(9'h020, 4'h1, 1'b1);
    lat = 4;
    acc(1, 1, SRP_WORD, 1, 20'h00104, 32'hCAFE_0104, 0);
    chk(r_flg, 0);
    chk(m_addr, 20'h10104);
    chk(mem_wpar, opar(32'hCAFE_0104));
    chk(mem_size, SRP_WORD);
    acc(0, 0, SRP_WORD, 1, 20'h10104, 0, 0);
    chk(r_data, 32'hCAFE_0104);
    chk(r_par, opar(32'hCAFE_0104));
  endtask
  task automatic t_protect;
    kset(9'h040, 4'h3, 1'b0);
    kset(9'h041, 4'h3, 1'b1);
    acc(1, 0, SRP_WORD, 3, 20'h20000, 32'h0000_AAAA, 0);
    chk(r_flg, 0);
    acc(1, 0, SRP_WORD, 5, 20'h20000, 32'h0000_BBBB, 0);
    chk(r_flg, 3'b001);
    chk(seen_mem, 0);
    acc(0, 0, SRP_WORD, 5, 20'h20000, 0, 0);
    chk(r_flg, 0);
    chk(r_data, 32'h0000_AAAA);
    acc(0, 0, SRP_WORD, 5, 20'h20800, 0, 0);
    chk(r_flg, 3'b001);
    acc(1, 0, SRP_WORD, 5, 20'h20800, 32'h1, 0);
    chk(r_flg, 3'b001);
    acc(0, 0, SRP_WORD, 3, 20'h20800, 0, 0);
    chk(r_data, 32'h0000_8200);
  endtask
  task automatic t_errors;
    lat = 1;
    for (int i = 1; i < 4; i++) begin
      acc(0, 0, srp_size_e'(i), 1, 20'h10100 + (20'h1 << (i - 1)), 0, 0);
      chk(r_flg, 3'b010);
    end
    acc(0, 0, SRP_DWORD, 1, 20'h10108, 0, 0);
    chk(r_flg, 0);
    acc(0, 0, SRP_HALF, 1, 20'h10102, 0, 0);
    chk(r_flg, 0);
    acc(0, 0, SRP_WORD, 1, 20'h10100, 0, 2'b01);
    chk(r_flg, 3'b100);
    acc(1, 0, SRP_WORD, 1, 20'h10100, 32'h55, 2'b10);
    chk(r_flg, 3'b100);
    bad_rpar = 1'b1;
    acc(0, 0, SRP_WORD, 1, 20'h10100, 0, 0);
    chk(r_flg, 3'b100);
    bad_rpar = 1'b0;
    cfg_units = 5'd4;
    acc(0, 0, SRP_WORD, 0, 20'h30000, 0, 0);
    chk(m_sel, 8'h02);
    cfg_units = 5'd2;
    acc(0, 0, SRP_WORD, 0, 20'h30000, 0, 0);
    chk(r_flg, 3'b010);
    cfg_units = 5'd5;
    acc(0, 0, SRP_WORD, 0, 20'h10000, 0, 0);
    chk(r_flg, 3'b010);
    cfg_units = 5'd6;
    acc(0, 0, SRP_WORD, 0, 20'h50000, 0, 0);
    chk(r_flg, 0);
    cfg_units = 5'd16;
    cab_sw[13:7] = 7'h70;
    cab_sw[55:49] = 7'h10;
    acc(0, 0, SRP_WORD, 0, 20'h30000, 0, 0);
    chk(m_sel, 8'h80);
    // Bad-parity base entry: the old base must stay in force
    bad_rpar = 1'b1;
    setkey(4'h2, 20'h10000);
    bad_rpar = 1'b0;
  endtask

  // Stimulus: reset for two cycles, then each scenario in turn
  initial begin
    {clk, srst, req_valid, req_write, req_reloc, req_addr_par, keyset_valid} = 7'h20;
    {keyset_mode, bad_rpar, seen_mem} = 3'b000;
    {program_status_word_key, req_key, keyset_key, req_wpar} = 16'h0000;
    {req_addr, req_wdata, keyset_blk} = '0;
    req_size = SRP_WORD;
    lat = 4'h2;
    cfg_units = 5'd16;
    cab_sw = {7'h70, 7'h60, 7'h50, 7'h40, 7'h30, 7'h20, 7'h10, 7'h00};
    n_mismatch = 0;
    num_checks = 0;
    mem_u.mem[18'h080] = 32'h0000_0000;
    mem_u.mem[18'h081] = 32'hFFF1_0000; // Bits above the address width are dropped
    repeat (2) @(posedge clk);
    #1;
    srst = 1'b0;
    setkey(4'h0, 20'h00000);
    t_reserved;
    setkey(4'h1, 20'h10000);
    t_reloc;
    t_protect;
    t_errors;
    close_out;
  end
  // Watchdog: the whole run needs a few hundred of the 10000 cycles allowed
  initial begin
    #80000;
    n_mismatch++;
    close_out;
  end
endmodule
